/* logic/dlr_pkg.sv */
package dlr_pkg;
	localparam int unsigned CLK_HZ        = 10_000_000;
	localparam int unsigned REFRESH_MS    = 250;
	localparam int unsigned REFRESH_CYC   = CLK_HZ / 1000 * REFRESH_MS;
	localparam int unsigned PULSE_MS      = 10;
	localparam int unsigned PULSE_CYC     = CLK_HZ / 1000 * PULSE_MS;
	localparam int unsigned PULSE_PER_S   = 49;
	localparam int unsigned PULSE_GAP_CYC = (CLK_HZ + PULSE_PER_S - 1) / PULSE_PER_S;
	localparam int unsigned HOLD_S        = 2;
	localparam int unsigned HOLD_CYC      = CLK_HZ * HOLD_S;
	localparam int unsigned NOFLOW_MIN    = 3;
	localparam int unsigned NOFLOW_CYC    = CLK_HZ * 60 * NOFLOW_MIN;
	localparam int unsigned SET_MS        = 1000;
	localparam int unsigned SET_CYC       = CLK_HZ / 1000 * SET_MS;
	localparam int unsigned DEB_MS        = 10;
	localparam int unsigned DEB_CYC       = CLK_HZ / 1000 * DEB_MS;
	localparam int unsigned F_SGL_HZ      = 10_000;
	localparam int unsigned F_DUAL_HZ     = 2_500;
	localparam int unsigned MINPER_SGL    = (CLK_HZ + F_SGL_HZ - 1) / F_SGL_HZ;
	localparam int unsigned MINPER_DUAL   = (CLK_HZ + F_DUAL_HZ - 1) / F_DUAL_HZ;
	localparam int unsigned RATE_MIN_MHZ  = 250;
	localparam int unsigned RATE_MAXPER   = CLK_HZ / RATE_MIN_MHZ * 1000;
	localparam int unsigned K_ONE         = 10_000;
	localparam int unsigned K_MIN         = 1;
	localparam int unsigned K_MAX         = 50_000 * K_ONE;
	localparam int unsigned NPTS          = 10;
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_KLIN   = 8'h04;
	localparam logic [7:0] OFS_CUTOFF = 8'h08;
	localparam logic [7:0] OFS_SIGTO  = 8'h0c;
	localparam logic [7:0] OFS_CLRMIN = 8'h10;
	localparam logic [7:0] OFS_TEMP   = 8'h14;
	localparam logic [7:0] OFS_NETTOT = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1c;
	localparam logic [7:0] OFS_TOTAL  = 8'h20;
	localparam logic [7:0] OFS_DELNO  = 8'h24;
	localparam logic [7:0] OFS_RATE   = 8'h28;
	localparam logic [7:0] OFS_EVENT  = 8'h2c;
	localparam logic [7:0] OFS_BATCH  = 8'h30;
	localparam logic [7:0] OFS_BASE   = 8'h34;
	localparam logic [7:0] OFS_VER    = 8'h38;
	localparam logic [7:0] OFS_KTAB   = 8'h40;
	localparam logic [7:0] OFS_BRK    = 8'h80;
	localparam int CB_PRESET = 0;
	localparam int CB_DUAL   = 1;
	localparam int CB_NONLIN = 2;
	localparam int CB_T3DIS  = 3;
	localparam int CB_COMM   = 4;
	localparam int CB_COMP   = 6;
	localparam int CB_TNET   = 7;
	localparam int EB_PRINT  = 0;
	localparam int EB_UPLOAD = 1;
	localparam int EB_ALMA   = 2;
	localparam int EB_ALMB   = 3;
	localparam int EB_OVSPD  = 4;
	localparam logic [7:0]  CTRL_RST   = 8'h00;
	localparam logic [31:0] KLIN_RST   = 32'(K_ONE);
	localparam logic [31:0] CUTOFF_RST = 32'h0;
	localparam logic [31:0] SIGTO_RST  = 32'(CLK_HZ);
	localparam logic [6:0]  CLRMIN_RST = 7'h0;
	localparam logic [23:0] BCD_RST    = 24'h0;
	typedef enum logic [2:0] {IT_BATCH = 3'b000, IT_BASE = 3'b001, IT_RATE = 3'b010,
		IT_SUM = 3'b011, IT_TEMP = 3'b100, IT_ALT = 3'b101, IT_VER = 3'b110} dlr_item_t;
	typedef enum logic [1:0] {DS_IDLE = 2'b00, DS_RUN = 2'b01, DS_STOP = 2'b10,
		DS_END = 2'b11} dlr_state_t;
	typedef enum logic [1:0] {CM_NONE = 2'b00, CM_PRN = 2'b01, CM_PC = 2'b10} dlr_comm_t;
	typedef struct packed {
		logic disp;
		logic rst;
		logic up;
		logic prn;
	} dlr_keys_t;
endpackage : dlr_pkg

/* logic/dlr_top.sv */
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
module dlr_top #(
	parameter int unsigned P_REFRESH = dlr_pkg::REFRESH_CYC,
	parameter int unsigned P_PULSE   = dlr_pkg::PULSE_CYC,
	parameter int unsigned P_GAP     = dlr_pkg::PULSE_GAP_CYC,
	parameter int unsigned P_HOLD    = dlr_pkg::HOLD_CYC,
	parameter int unsigned P_NOFLOW  = dlr_pkg::NOFLOW_CYC,
	parameter int unsigned P_SET     = dlr_pkg::SET_CYC,
	parameter int unsigned P_DEB     = dlr_pkg::DEB_CYC,
	parameter int unsigned P_RATEMAX = dlr_pkg::RATE_MAXPER,
	// arbitrary version code
	parameter logic [31:0] P_VERSION = 32'h0000_0101
) (
	// system
	input  wire logic                CLK_SYS,
	input  wire logic                RESETN,
	// register bus
	input  wire logic [7:0]          S_AXI_AWADDR,
	input  wire logic                S_AXI_AWVALID,
	output logic                     S_AXI_AWREADY,
	input  wire logic [31:0]         S_AXI_WDATA,
	input  wire logic [3:0]          S_AXI_WSTRB,
	input  wire logic                S_AXI_WVALID,
	output logic                     S_AXI_WREADY,
	output logic [1:0]               S_AXI_BRESP,
	output logic                     S_AXI_BVALID,
	input  wire logic                S_AXI_BREADY,
	input  wire logic [7:0]          S_AXI_ARADDR,
	input  wire logic                S_AXI_ARVALID,
	output logic                     S_AXI_ARREADY,
	output logic [31:0]              S_AXI_RDATA,
	output logic [1:0]               S_AXI_RRESP,
	output logic                     S_AXI_RVALID,
	input  wire logic                S_AXI_RREADY,
	// field inputs
	input  wire logic                FLOW_A,
	input  wire logic                FLOW_B,
	input  wire dlr_pkg::dlr_keys_t  KEYS,
	// field outputs
	output logic                     RUN_RELAY,
	output logic                     STAGE2_RELAY,
	output logic                     PULSE_OUT,
	output logic                     ALARM,
	output logic                     END_DELIV,
	// display
	output dlr_pkg::dlr_item_t       DISP_ITEM,
	output logic [31:0]              DISP_VALUE,
	output logic [5:0]               DISP_BLINK,
	output logic                     DISP_SET
);
	import dlr_pkg::*;

	function automatic logic [31:0] wmask(logic [31:0] o, logic [31:0] n, logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++)
			if (s[b]) r[b*8 +: 8] = n[b*8 +: 8];
		return r;
	endfunction : wmask

	function automatic logic [31:0] kclamp(logic [31:0] k);
		if (k < K_MIN) return 32'(K_MIN);
		if (k > K_MAX) return 32'(K_MAX);
		return k;
	endfunction : kclamp

	function automatic logic mapped(logic [5:0] i);
		return (i <= OFS_VER[7:2]) || (i >= OFS_KTAB[7:2] && i < 6'(OFS_KTAB[7:2] + NPTS))
			|| (i >= OFS_BRK[7:2] && i < 6'(OFS_BRK[7:2] + NPTS));
	endfunction : mapped

	function automatic logic [23:0] bcd_inc(logic [23:0] v, logic [2:0] s);
		logic [23:0] r;
		logic [3:0]  d;
		r = v;
		d = v[s*4 +: 4];
		r[s*4 +: 4] = (d >= 4'h9) ? 4'h0 : d + 4'h1;
		return r;
	endfunction : bcd_inc

	function automatic dlr_item_t next_item(dlr_item_t c, logic pre, logic comp);
		case (c)
			IT_BATCH: return comp ? IT_BASE : IT_RATE;
			IT_BASE:  return IT_RATE;
			IT_RATE:  return IT_SUM;
			IT_SUM:   return IT_TEMP;
			IT_TEMP:  return comp ? IT_ALT : IT_VER;
			IT_ALT:   return IT_VER;
			default:  return pre ? IT_BATCH : (comp ? IT_BASE : IT_RATE);
		endcase
	endfunction : next_item

	// configuration and status
	logic [7:0]  ctrl_q;
	logic [31:0] klin_q, cutoff_q, sigto_q, temp_q, net_q;
	logic [6:0]  clrmin_q;
	logic [31:0] ktab_q [NPTS];
	logic [31:0] brk_q [NPTS];
	logic [4:0]  evt_q;
	logic [23:0] batch_q, base_q;
	dlr_state_t  st_q;
	logic [31:0] total_q, delno_q, rate_q;
	dlr_item_t   item_q;
	logic        edit_q;

	// bus slave: one write and one read in flight
	logic [5:0]  aw_q, ar_idx;
	logic        awv_q, wv_q;
	logic [31:0] wd_q;
	logic [3:0]  ws_q;
	logic        wr_en;
	logic [31:0] rd_mux;
	assign S_AXI_AWREADY = !awv_q && !S_AXI_BVALID;
	assign S_AXI_WREADY  = !wv_q && !S_AXI_BVALID;
	assign S_AXI_ARREADY = !S_AXI_RVALID;
	assign wr_en         = awv_q && wv_q && !S_AXI_BVALID;
	assign ar_idx        = S_AXI_ARADDR[7:2];

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			awv_q <= 1'b0;
			wv_q <= 1'b0;
			aw_q <= 6'h0;
			wd_q <= 32'h0;
			ws_q <= 4'h0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= 2'h0;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				awv_q <= 1'b1;
				aw_q <= S_AXI_AWADDR[7:2];
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				wv_q <= 1'b1;
				wd_q <= S_AXI_WDATA;
				ws_q <= S_AXI_WSTRB;
			end
			if (wr_en) begin
				awv_q <= 1'b0;
				wv_q <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= mapped(aw_q) ? 2'h0 : 2'h2;
			end else if (S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	always_comb begin
		rd_mux = 32'h0;
		case (ar_idx)
			OFS_CTRL[7:2]:   rd_mux = {24'h0, ctrl_q};
			OFS_KLIN[7:2]:   rd_mux = klin_q;
			OFS_CUTOFF[7:2]: rd_mux = cutoff_q;
			OFS_SIGTO[7:2]:  rd_mux = sigto_q;
			OFS_CLRMIN[7:2]: rd_mux = {25'h0, clrmin_q};
			OFS_TEMP[7:2]:   rd_mux = temp_q;
			OFS_NETTOT[7:2]: rd_mux = net_q;
			OFS_STATUS[7:2]: rd_mux = {24'h0, edit_q, item_q, STAGE2_RELAY, RUN_RELAY, st_q};
			OFS_TOTAL[7:2]:  rd_mux = total_q;
			OFS_DELNO[7:2]:  rd_mux = delno_q;
			OFS_RATE[7:2]:   rd_mux = rate_q;
			OFS_EVENT[7:2]:  rd_mux = {27'h0, evt_q};
			OFS_BATCH[7:2]:  rd_mux = {8'h0, batch_q};
			OFS_BASE[7:2]:   rd_mux = {8'h0, base_q};
			OFS_VER[7:2]:    rd_mux = P_VERSION;
			default: begin
				for (int i = 0; i < NPTS; i++) begin
					if (ar_idx == 6'(OFS_KTAB[7:2] + i)) rd_mux = ktab_q[i];
					if (ar_idx == 6'(OFS_BRK[7:2] + i)) rd_mux = brk_q[i];
				end
			end
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0;
			S_AXI_RRESP <= 2'h0;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA <= rd_mux;
			S_AXI_RRESP <= mapped(ar_idx) ? 2'h0 : 2'h2;
		end else if (S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end

	// setup registers; factors clamped into range on write
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			ctrl_q <= CTRL_RST;
			klin_q <= KLIN_RST;
			cutoff_q <= CUTOFF_RST;
			sigto_q <= SIGTO_RST;
			clrmin_q <= CLRMIN_RST;
			temp_q <= 32'h0;
			net_q <= 32'h0;
			for (int i = 0; i < NPTS; i++) begin
				ktab_q[i] <= KLIN_RST;
				brk_q[i] <= 32'h0;
			end
		end else if (wr_en) begin
			case (aw_q)
				OFS_CTRL[7:2]:   ctrl_q <= 8'(wmask({24'h0, ctrl_q}, wd_q, ws_q));
				OFS_KLIN[7:2]:   klin_q <= kclamp(wmask(klin_q, wd_q, ws_q));
				OFS_CUTOFF[7:2]: cutoff_q <= wmask(cutoff_q, wd_q, ws_q);
				OFS_SIGTO[7:2]:  sigto_q <= wmask(sigto_q, wd_q, ws_q);
				OFS_CLRMIN[7:2]: if (ws_q[0]) clrmin_q <= (wd_q[6:0] > 7'h63) ? 7'h63 : wd_q[6:0];
				OFS_TEMP[7:2]:   temp_q <= wmask(temp_q, wd_q, ws_q);
				OFS_NETTOT[7:2]: net_q <= wmask(net_q, wd_q, ws_q);
				default: begin
					for (int i = 0; i < NPTS; i++) begin
						if (aw_q == 6'(OFS_KTAB[7:2] + i))
							ktab_q[i] <= kclamp(wmask(ktab_q[i], wd_q, ws_q));
						if (aw_q == 6'(OFS_BRK[7:2] + i))
							brk_q[i] <= wmask(brk_q[i], wd_q, ws_q);
					end
				end
			endcase
		end
	end

	// flow pickups: three-stage sync, change taken when stages two and three agree
	logic [2:0]  fs_q [2];
	logic [1:0]  flv_q, rise, acc, ovs;
	logic [31:0] per_q [2];
	logic [31:0] minper;
	logic [1:0]  lead_q;
	logic        flow_ev, alma_set, almb_set, dual;
	assign dual   = ctrl_q[CB_DUAL];
	assign minper = dual ? 32'(MINPER_DUAL) : 32'(MINPER_SGL);

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			rise[i] = (fs_q[i][2] == fs_q[i][1]) && fs_q[i][2] && !flv_q[i];
			ovs[i]  = rise[i] && per_q[i] < minper;
			acc[i]  = rise[i] && !ovs[i] && (cutoff_q == 32'h0 || per_q[i] <= cutoff_q);
		end
		if (!dual) acc[1] = 1'b0;
	end
	assign flow_ev  = acc[0];
	// a channel two pulses behind its partner has dropped one
	assign almb_set = dual && acc[0] && !acc[1] && lead_q == 2'b01;
	assign alma_set = dual && acc[1] && !acc[0] && lead_q == 2'b10;

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			for (int i = 0; i < 2; i++) begin
				fs_q[i] <= 3'h0;
				per_q[i] <= 32'hffff_ffff;
			end
			flv_q <= 2'h0;
			lead_q <= 2'h0;
			rate_q <= 32'h0;
		end else begin
			fs_q[0] <= {fs_q[0][1:0], FLOW_A};
			fs_q[1] <= {fs_q[1][1:0], FLOW_B};
			for (int i = 0; i < 2; i++) begin
				if (fs_q[i][2] == fs_q[i][1]) flv_q[i] <= fs_q[i][2];
				per_q[i] <= rise[i] ? 32'h1 : per_q[i] + {31'h0, ~&per_q[i]};
			end
			if (!dual) lead_q <= 2'h0;
			else if (acc[0] && !acc[1]) lead_q <= (lead_q == 2'b10) ? 2'b00 : 2'b01;
			else if (acc[1] && !acc[0]) lead_q <= (lead_q == 2'b01) ? 2'b00 : 2'b10;
			if (flow_ev) rate_q <= (per_q[0] <= P_RATEMAX) ? per_q[0] : 32'h0;
			else if (per_q[0] > P_RATEMAX) rate_q <= 32'h0;
		end
	end

	// scaling: factor in ten-thousandths, whole units drained one per cycle
	logic [31:0] kcur, frac_q;
	logic [15:0] pend_q;
	logic        clr_tot, unit, pstart;
	logic [31:0] oc_q;
	always_comb begin
		kcur = klin_q;
		if (ctrl_q[CB_NONLIN]) begin
			kcur = ktab_q[NPTS-1];
			for (int i = NPTS - 1; i >= 0; i--)
				if (per_q[0] >= brk_q[i]) kcur = ktab_q[i];
		end
	end
	assign unit   = frac_q >= K_ONE;
	assign pstart = oc_q == 32'h0 && pend_q != 16'h0;

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			frac_q <= 32'h0;
			total_q <= 32'h0;
		end else if (clr_tot) begin
			frac_q <= 32'h0;
			total_q <= 32'h0;
		end else begin
			// totals keep running whatever the relays do, so overrun is recorded
			frac_q <= frac_q - (unit ? 32'(K_ONE) : 32'h0) + (flow_ev ? kcur : 32'h0);
			if (unit) total_q <= total_q + 32'h1;
		end
	end

	// pulse queue: increment and issue in one cycle cancel; saturates rather than wraps
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			pend_q <= 16'h0;
			oc_q <= 32'h0;
			PULSE_OUT <= 1'b0;
		end else begin
			if (unit && !clr_tot && !pstart) pend_q <= pend_q + {15'h0, ~&pend_q};
			else if (pstart && !(unit && !clr_tot)) pend_q <= pend_q - 16'h1;
			oc_q <= pstart ? P_GAP - 1 : oc_q - {31'h0, oc_q != 32'h0};
			PULSE_OUT <= pstart || (oc_q > P_GAP - P_PULSE);
		end
	end

	// keypad: three-stage sync then stable-for-debounce before a press counts
	logic [2:0]  ks_q [4];
	logic [3:0]  kst_q, kpr_q;
	logic [31:0] kc_q [4];
	dlr_keys_t   kst, kp;
	assign kst = dlr_keys_t'(kst_q);
	assign kp  = dlr_keys_t'(kpr_q);
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			for (int i = 0; i < 4; i++) begin
				ks_q[i] <= 3'h0;
				kc_q[i] <= 32'h0;
			end
			kst_q <= 4'h0;
			kpr_q <= 4'h0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				ks_q[i] <= {ks_q[i][1:0], KEYS[i]};
				kpr_q[i] <= 1'b0;
				if (ks_q[i][2] != ks_q[i][1] || ks_q[i][2] == kst_q[i]) begin
					kc_q[i] <= 32'h0;
				end else if (kc_q[i] >= P_DEB - 1) begin
					kc_q[i] <= 32'h0;
					kst_q[i] <= ks_q[i][2];
					kpr_q[i] <= ks_q[i][2];
				end else begin
					kc_q[i] <= kc_q[i] + 32'h1;
				end
			end
		end
	end

	// display menu and digit editing
	logic [23:0] edv_q;
	logic [2:0]  dsel_q;
	logic [31:0] set_q, ref_q, shown;
	logic        editable;
	assign editable = item_q == IT_BATCH || item_q == IT_BASE;
	always_comb begin
		case (item_q)
			IT_BATCH: shown = {8'h0, batch_q};
			IT_BASE:  shown = {8'h0, base_q};
			IT_RATE:  shown = rate_q;
			IT_SUM:   shown = total_q;
			IT_TEMP:  shown = temp_q;
			IT_ALT:   shown = ctrl_q[CB_TNET] ? total_q : net_q;
			default:  shown = P_VERSION;
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			item_q <= IT_RATE;
			edit_q <= 1'b0;
			dsel_q <= 3'h5;
			edv_q <= BCD_RST;
			batch_q <= BCD_RST;
			base_q <= BCD_RST;
			set_q <= 32'h0;
		end else begin
			set_q <= set_q - {31'h0, set_q != 32'h0};
			if (wr_en && aw_q == OFS_BATCH[7:2]) batch_q <= 24'(wmask({8'h0, batch_q}, wd_q, ws_q));
			if (wr_en && aw_q == OFS_BASE[7:2]) base_q <= 24'(wmask({8'h0, base_q}, wd_q, ws_q));
			if (kp.disp) begin
				if (edit_q) begin
					edit_q <= 1'b0;
					set_q <= P_SET;
					if (item_q == IT_BATCH) batch_q <= edv_q;
					else base_q <= edv_q;
				end else begin
					item_q <= next_item(item_q, ctrl_q[CB_PRESET], ctrl_q[CB_COMP]);
				end
			end else if (kp.rst) begin
				if (!edit_q && editable) begin
					edit_q <= 1'b1;
					dsel_q <= 3'h5;
					edv_q <= (item_q == IT_BATCH) ? batch_q : base_q;
				end else if (edit_q) begin
					dsel_q <= (dsel_q == 3'h0) ? 3'h5 : dsel_q - 3'h1;
				end
			end else if (kp.up && edit_q) begin
				edv_q <= bcd_inc(edv_q, dsel_q);
			end
		end
	end

	// display latch; numbers change only on the refresh tick, edits show at once
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			ref_q <= 32'h0;
			DISP_VALUE <= 32'h0;
			DISP_BLINK <= 6'h0;
			DISP_SET <= 1'b0;
			DISP_ITEM <= IT_RATE;
		end else begin
			ref_q <= (ref_q == 32'h0) ? P_REFRESH - 1 : ref_q - 32'h1;
			if (edit_q) DISP_VALUE <= {8'h0, edv_q};
			else if (ref_q == 32'h0) DISP_VALUE <= shown;
			DISP_BLINK <= edit_q ? 6'(6'h01 << dsel_q) : 6'h0;
			DISP_SET <= set_q != 32'h0;
			DISP_ITEM <= item_q;
		end
	end

	// delivery control
	logic [31:0] hold_q, nf_q;
	logic        hold_fire, start_ev, end_ev, t3, hold_ok;
	dlr_state_t  st_d;
	// a press on an editable item is an edit, never a start
	assign hold_ok   = kst.rst && !edit_q && !editable;
	assign hold_fire = hold_ok && hold_q == P_HOLD - 1;
	assign start_ev  = hold_fire && (st_q == DS_IDLE || st_q == DS_END);
	assign t3        = !ctrl_q[CB_T3DIS] && nf_q >= P_NOFLOW;
	assign end_ev    = st_d == DS_END && st_q != DS_END;
	assign clr_tot   = start_ev || (end_ev && total_q < {25'h0, clrmin_q});

	always_comb begin
		st_d = st_q;
		case (st_q)
			DS_RUN: begin
				if (t3) st_d = DS_END;
				else if (kp.prn || alma_set || almb_set) st_d = DS_STOP;
			end
			DS_STOP: if (t3 || nf_q >= sigto_q) st_d = DS_END;
			default: if (start_ev) st_d = DS_RUN;
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			st_q <= DS_IDLE;
			hold_q <= 32'h0;
			nf_q <= 32'h0;
			delno_q <= 32'h0;
			RUN_RELAY <= 1'b0;
			STAGE2_RELAY <= 1'b0;
			END_DELIV <= 1'b0;
		end else begin
			st_q <= st_d;
			hold_q <= !hold_ok ? 32'h0 : hold_q + {31'h0, hold_q < P_HOLD};
			nf_q <= (flow_ev || start_ev) ? 32'h0 : nf_q + {31'h0, ~&nf_q};
			if (start_ev) delno_q <= delno_q + 32'h1;
			RUN_RELAY <= st_d == DS_RUN;
			STAGE2_RELAY <= st_d == DS_RUN && ctrl_q[CB_PRESET];
			END_DELIV <= st_d == DS_END;
		end
	end

	// sticky events, write one to clear; a new event wins over the clear
	logic [4:0] ev_set, ev_clr;
	logic       big;
	assign big = total_q > {25'h0, clrmin_q};
	always_comb begin
		ev_set = 5'h0;
		ev_set[EB_PRINT]  = end_ev && dlr_comm_t'(ctrl_q[CB_COMM +: 2]) == CM_PRN && big;
		ev_set[EB_UPLOAD] = end_ev && dlr_comm_t'(ctrl_q[CB_COMM +: 2]) == CM_PC && big;
		ev_set[EB_ALMA]   = alma_set;
		ev_set[EB_ALMB]   = almb_set;
		ev_set[EB_OVSPD]  = |ovs;
		ev_clr = (wr_en && aw_q == OFS_EVENT[7:2] && ws_q[0]) ? wd_q[4:0] : 5'h0;
	end
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			evt_q <= 5'h0;
			ALARM <= 1'b0;
		end else begin
			evt_q <= (evt_q & ~ev_clr) | ev_set;
			ALARM <= evt_q[EB_ALMA] || evt_q[EB_ALMB];
		end
	end
endmodule : dlr_top

/* testbench/dlr_sva.sv */
`timescale 1ns/100ps
module dlr_sva (
	// system
	input logic               CLK_SYS,
	input logic               RESETN,
	// bus handshakes
	input logic               S_AXI_AWVALID,
	input logic               S_AXI_AWREADY,
	input logic               S_AXI_WVALID,
	input logic               S_AXI_WREADY,
	input logic               S_AXI_BVALID,
	input logic               S_AXI_ARVALID,
	input logic               S_AXI_ARREADY,
	input logic               S_AXI_RVALID,
	// field and display
	input dlr_pkg::dlr_keys_t KEYS,
	input logic               RUN_RELAY,
	input logic               PULSE_OUT,
	input logic               END_DELIV,
	input logic [5:0]         DISP_BLINK,
	input logic               DISP_SET
);
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RESETN);
	// counts fixed to the short simulation parameters
	a_pulse_width: assert property (
		$rose(PULSE_OUT) |-> PULSE_OUT [*4] ##1 !PULSE_OUT) else $error("pulse width");
	a_pulse_gap: assert property (
		$rose(PULSE_OUT) |=> !$rose(PULSE_OUT) [*8]) else $error("pulses too close");
	a_start_held: assert property (
		$rose(RUN_RELAY) |-> KEYS.rst && !END_DELIV) else $error("relay closed unasked");
	a_end_open: assert property (
		END_DELIV |-> !RUN_RELAY) else $error("relay closed at end");
	a_blink_one: assert property (
		$onehot0(DISP_BLINK)) else $error("several digits blink");
	a_set_shown: assert property (
		$rose(DISP_SET) |-> DISP_SET [*8]) else $error("confirmation too short");
	a_write_resp: assert property (
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
		else $error("no write response");
	a_read_resp: assert property (
		S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
		else $error("no read data");
endmodule : dlr_sva
bind dlr_top dlr_sva i_sva (.CLK_SYS, .RESETN, .S_AXI_AWVALID, .S_AXI_AWREADY,
	.S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_ARVALID, .S_AXI_ARREADY,
	.S_AXI_RVALID, .KEYS, .RUN_RELAY, .PULSE_OUT, .END_DELIV, .DISP_BLINK, .DISP_SET);

/* testbench/dlr_field.sv */
`timescale 1ns/100ps
module dlr_field (
	input logic  clk,
	input logic  go,
	input logic  skip_b,
	input int    per,
	output logic flow_a = 1'b0,
	output logic flow_b = 1'b0
);
	int cnt = 0;
	// pickups in step unless skip_b drops channel b, period above the floor
	always @(posedge clk) begin
		cnt <= (go && cnt < per - 1) ? cnt + 1 : 0;
		flow_a <= go && cnt > per / 2;
		flow_b <= go && !skip_b && cnt > per / 2;
	end
endmodule : dlr_field

/* testbench/dlr_top_tb.sv */
`timescale 1ns/100ps
module dlr_top_tb;
	import dlr_pkg::*;
	logic        CLK_SYS = 0, RESETN = 0, go = 0, S_AXI_AWVALID = 0, S_AXI_WVALID = 0;
	logic        S_AXI_BREADY = 0, S_AXI_ARVALID = 0, S_AXI_RREADY = 0, skip_b = 0;
	logic [7:0]  S_AXI_AWADDR = '0, S_AXI_ARADDR = '0;
	logic [31:0] S_AXI_WDATA = '0, S_AXI_RDATA, DISP_VALUE;
	logic [3:0]  S_AXI_WSTRB = 4'hf;
	logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
	logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
	logic        FLOW_A, FLOW_B, RUN_RELAY, STAGE2_RELAY, PULSE_OUT, ALARM, END_DELIV;
	logic        DISP_SET;
	logic [5:0]  DISP_BLINK;
	dlr_item_t   DISP_ITEM, item = IT_RATE;
	dlr_keys_t   KEYS = '0;
	int          failures = 0, samples_checked = 0, pulses = 0, per;
	// pulse gap, confirmation time and rate span keep their real values
	dlr_top #(.P_REFRESH(20), .P_PULSE(4), .P_HOLD(50), .P_NOFLOW(200),
		.P_DEB(3)) i_dut (.CLK_SYS, .RESETN,
		.S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB,
		.S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
		.S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
		.S_AXI_RVALID, .S_AXI_RREADY, .FLOW_A, .FLOW_B, .KEYS, .RUN_RELAY,
		.STAGE2_RELAY, .PULSE_OUT, .ALARM, .END_DELIV, .DISP_ITEM, .DISP_VALUE,
		.DISP_BLINK, .DISP_SET);
	dlr_field i_fld (.clk(CLK_SYS), .go, .skip_b, .per, .flow_a(FLOW_A), .flow_b(FLOW_B));
	initial forever #50 CLK_SYS = ~CLK_SYS;
	always @(posedge PULSE_OUT) pulses++;
	task automatic end_sim;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] s, e);
		samples_checked++;
		if (s !== e) begin
			failures++;
			$display("BAD %0t got %h exp %h", $time, s, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic ta, tw;
		@(posedge CLK_SYS);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= d;
		S_AXI_AWVALID <= 1;
		S_AXI_WVALID <= 1;
		S_AXI_BREADY <= 1;
		do begin
			@(negedge CLK_SYS);
			ta = S_AXI_AWREADY && S_AXI_AWVALID;
			tw = S_AXI_WREADY && S_AXI_WVALID;
			@(posedge CLK_SYS);
			if (ta) S_AXI_AWVALID <= 0;
			if (tw) S_AXI_WVALID <= 0;
		end while (S_AXI_AWVALID && !ta || S_AXI_WVALID && !tw);
		do @(negedge CLK_SYS); while (!S_AXI_BVALID);
		chk(S_AXI_BRESP, e);
		@(posedge CLK_SYS);
		S_AXI_BREADY <= 0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		@(posedge CLK_SYS);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1;
		S_AXI_RREADY <= 1;
		do @(negedge CLK_SYS); while (!S_AXI_ARREADY);
		@(posedge CLK_SYS);
		S_AXI_ARVALID <= 0;
		do @(negedge CLK_SYS); while (!S_AXI_RVALID);
		chk(S_AXI_RDATA, e);
		chk(S_AXI_RRESP, r);
		@(posedge CLK_SYS);
		S_AXI_RREADY <= 0;
	endtask : rd
	task automatic key(input int b, n);
		@(posedge CLK_SYS);
		KEYS[b] <= 1;
		repeat (n) @(posedge CLK_SYS);
		KEYS[b] <= 0;
		repeat (12) @(posedge CLK_SYS);
	endtask : key
	function automatic dlr_item_t nxt(dlr_item_t i, logic p);
		do i = dlr_item_t'(i == IT_VER ? 0 : i + 1);
		while (i == IT_BATCH && !p || (i == IT_BASE || i == IT_ALT) && !p);
		return i;
	endfunction : nxt
	task automatic dk(input logic p);
		item = nxt(item, p);
		key(3, 10);
		chk(DISP_ITEM, item);
		if (item == IT_ALT) begin
			repeat (21) @(posedge CLK_SYS);
			chk(DISP_VALUE, 32'h5a5a);
		end
	endtask : dk
	initial begin
		repeat (40000) @(posedge CLK_SYS);
		failures++;
		end_sim;
	end
	initial begin
		void'($urandom(32'h8413ca69));
		repeat (20) @(posedge CLK_SYS);
		RESETN <= 1;
		rd(OFS_CTRL, 0, 0);
		rd(OFS_SIGTO, CLK_HZ, 0);
		rd(8'hfc, 0, 2);
		wr(8'hfc, 1, 2);
		per = $urandom % 100;
		wr(OFS_CLRMIN, per, 0);
		rd(OFS_CLRMIN, per, 0);
		rd(OFS_KLIN, K_ONE, 0);
		wr(OFS_KLIN, 0, 0);
		rd(OFS_KLIN, K_MIN, 0);
		wr(OFS_KLIN, K_MAX + 1, 0);
		rd(OFS_KLIN, K_MAX, 0);
		wr(OFS_KLIN, 5 * K_ONE, 0);
		wr(OFS_NETTOT, 32'h5a5a, 0);
		chk(DISP_ITEM, IT_RATE);
		repeat (4) dk(0);
		wr(OFS_CTRL, 8'h41, 0);
		repeat (7) dk(1);
		for (int t = 0; t < 2; t++) begin
			while (item != dlr_item_t'(t)) dk(1);
			key(2, 10);
			chk(DISP_BLINK, 6'h20);
			key(1, 10);
			chk(DISP_VALUE, 32'h100000);
			key(2, 10);
			chk(DISP_BLINK, 6'h10);
			key(1, 10);
			chk(DISP_SET, t);
			key(3, 10);
			chk(DISP_SET, 1);
			rd(t ? OFS_BASE : OFS_BATCH, 32'h110000, 0);
		end
		wr(OFS_CTRL, 0, 0);
		dk(0);
		key(2, 30);
		chk(RUN_RELAY, 0);
		rd(OFS_DELNO, 0, 0);
		for (int m = 0; m < 2; m++) begin
			wr(OFS_CTRL, m ? 8'h08 : 8'h00, 0);
			key(2, 80);
			chk(RUN_RELAY, 1);
			chk(STAGE2_RELAY, 0);
			rd(OFS_DELNO, m + 1, 0);
			if (m == 0) begin
				repeat (250) @(posedge CLK_SYS);
				chk(END_DELIV, 1);
			end
		end
		per = 1100 + $urandom % 200;
		go <= 1;
		repeat (5 * per) @(posedge CLK_SYS);
		go <= 0;
		repeat (400) @(posedge CLK_SYS);
		chk(RUN_RELAY, 1);
		chk(pulses, 1); // rest wait in the queue behind the 1/49 s gap
		rd(OFS_TOTAL, 25, 0);
		wr(OFS_SIGTO, 100, 0);
		key(0, 10);
		chk(RUN_RELAY, 0);
		repeat (150) @(posedge CLK_SYS);
		chk(END_DELIV, 1);
		// dual mode, channel b silent: first edge overspeed, third trips the alarm
		wr(OFS_CTRL, 8'h0a, 0);
		key(2, 80);
		per = 4100 + $urandom % 200;
		skip_b <= 1;
		go <= 1;
		repeat (3 * per) @(posedge CLK_SYS);
		go <= 0;
		chk(ALARM, 1);
		chk(RUN_RELAY, 0);
		end_sim;
	end
endmodule : dlr_top_tb
